// >>> hdl/epm_map.vh
// Constants and timing counts for the E1 performance monitor
// Summary of operation
// RQ1 - Error-free figure: percent of error-free seconds; code gives only the o_error_free_seconds count
// RQ2 - Errored-second ratio over available seconds, times 100; code gives only the o_errored_seconds and o_avail_seconds counts
// RQ3 - Severely errored ratio over available seconds, times 100; code gives only the o_severely_errored_seconds and o_avail_seconds counts
// RQ4 - Block error ratio over seconds times 1000; code gives only the o_background_block_errors count
// RQ5 - Recompute six check bits for each frame
// RQ6 - Mismatch marks frame bad, counts one error
// RQ7 - Same-polarity consecutive marks count a violation
// RQ8 - Selected DTR or RTS loss flags signal loss
// RQ9 - History holds 96 intervals of 15 minutes
// RQ10 - Running counters kept apart from history
// RQ11 - User alarm text up to 20 characters
// RQ12 - Event log covers most recent 24 hours
// RQ13 - Absent port position reports blank status
// RQ14 - Clear command zeroes counters, keeps history
// RQ15 - Errored second: any frame or check error
// RQ16 - Severe second: 300 or more errors
// RQ17 - Unavailable after 10 consecutive severe seconds
// RQ18 - One-second tick from system clock
// RQ19 - Interval end stores counts, oldest dropped
`ifndef EPM_MAP_VH
`define EPM_MAP_VH
`define EPM_CLK_HZ        50000000
`define EPM_SEC_CYCLES    (`EPM_CLK_HZ * 1)
`define EPM_INTERVAL_S    900
`define EPM_HIST_DEPTH    96
`define EPM_SES_THRESH    300
`define EPM_UAS_RUN       10
`define EPM_BLOCKS_PER_S  1000
`define EPM_PERCENT       100
`define EPM_ALARM_CHARS   20
`define EPM_DAY_S         86400
`define EPM_PORT_NORMAL   2'h0
`define EPM_PORT_LOSS     2'h1
`define EPM_PORT_BLANK    2'h2
`endif

// >>> hdl/epm_hist_mem.v
// Circular interval history memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module epm_hist_mem #(
   parameter DEPTH = 96,
   parameter AW    = 7,
   parameter DW    = 64
) (
   input  wire          i_clk_sys,
   input  wire          i_wr_en,
   input  wire [AW-1:0] i_wr_addr,
   input  wire [DW-1:0] i_wr_data,
   input  wire [AW-1:0] i_rd_addr,
   output reg  [DW-1:0] o_rd_data
);
   reg [DW-1:0] mem [0:DEPTH-1];
   always @(posedge i_clk_sys) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
   end
endmodule // epm_hist_mem
`default_nettype wire

// >>> hdl/epm_crc4.v
// Frame check calculator: six check bits over a serial frame
`timescale 1ns/100ps
`default_nettype none
module epm_crc4 #(
   parameter CW = 6
) (
   input  wire          i_clk_sys,
   input  wire          i_reset,
   input  wire          i_bit_valid,
   input  wire          i_bit,
   input  wire          i_frame_start,
   output reg  [CW-1:0] o_crc
);
   // Polynomial x^6+x+1; state restarts at each frame start
   wire [CW-1:0] base_w = i_frame_start ? {CW{1'b0}} : o_crc;
   wire          fb_w   = base_w[CW-1] ^ i_bit;
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_crc <= {CW{1'b0}};
      end else if (i_bit_valid) begin
         o_crc <= {base_w[CW-2:1], base_w[0] ^ fb_w, fb_w}; // RQ5
      end else if (i_frame_start) begin
         o_crc <= {CW{1'b0}};
      end
   end
endmodule // epm_crc4
`default_nettype wire

// >>> hdl/epm_monitor.v
// E1 performance monitor top: error counting, seconds, history
`timescale 1ns/100ps
`default_nettype none
`include "epm_map.vh"
module epm_monitor #(
   parameter SEC_CYCLES = `EPM_SEC_CYCLES,
   parameter INT_SECS   = `EPM_INTERVAL_S,
   parameter DEPTH      = `EPM_HIST_DEPTH,
   parameter CW         = 32
) (
   input  wire          i_clk_sys,
   input  wire          i_reset,
   input  wire          i_bit_valid,
   input  wire          i_bit,
   input  wire          i_frame_start,
   input  wire          i_frame_end,
   input  wire [5:0]    i_rx_crc,
   input  wire          i_frame_err,
   input  wire          i_oof,
   input  wire          i_mark_valid,
   input  wire          i_mark_pos,
   input  wire          i_dtr,
   input  wire          i_rts,
   input  wire          i_sel_rts,
   input  wire          i_port_present,
   input  wire          i_user_alarm_en,
   input  wire [7:0]    i_alarm_char,
   input  wire [4:0]    i_alarm_idx,
   input  wire          i_alarm_wr,
   input  wire [4:0]    i_alarm_rd_idx,
   input  wire          i_clear,
   input  wire [6:0]    i_hist_rd_idx,
   output reg  [CW-1:0] o_crc_errors,
   output reg  [CW-1:0] o_line_code_violations,
   output reg  [CW-1:0] o_errored_seconds,
   output reg  [CW-1:0] o_severely_errored_seconds,
   output reg  [CW-1:0] o_unavailable_seconds,
   output reg  [CW-1:0] o_background_block_errors,
   output reg  [CW-1:0] o_avail_seconds,
   output reg  [CW-1:0] o_error_free_seconds,
   output reg  [CW-1:0] o_total_seconds,
   output reg  [9:0]    o_interval_timer,
   output reg           o_unavailable_state,
   output reg  [1:0]    o_port_status,
   output reg  [7:0]    o_alarm_char,
   output reg           o_alarm_user,
   output reg           o_frame_bad,
   output reg           o_sec_tick,
   output reg  [6:0]    o_valid_intervals,
   output reg  [63:0]   o_hist_data
);
   ////////////////////////////////////////////////////////////////////////
   // Frame check
   wire [5:0] calc_crc_w;
   epm_crc4 #(.CW(6)) u_crc (
      .i_clk_sys     (i_clk_sys),
      .i_reset       (i_reset),
      .i_bit_valid   (i_bit_valid),
      .i_bit         (i_bit),
      .i_frame_start (i_frame_start),
      .o_crc         (calc_crc_w)
   );
   wire crc_bad_w = i_frame_end && (calc_crc_w != i_rx_crc); // RQ6

   ////////////////////////////////////////////////////////////////////////
   // Line code: consecutive marks must alternate polarity
   reg  last_pol_q;
   reg  have_mark_q;
   wire cv_w = i_mark_valid && have_mark_q && (i_mark_pos == last_pol_q); // RQ7
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         last_pol_q  <= 1'b0;
         have_mark_q <= 1'b0;
      end else if (i_mark_valid) begin
         last_pol_q  <= i_mark_pos;
         have_mark_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One-second timebase and interval timer
   reg [31:0] sec_cnt_q;
   wire       tick_w = (sec_cnt_q == SEC_CYCLES - 1); // RQ18
   wire       int_end_w = tick_w && (o_interval_timer == INT_SECS - 1);
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         sec_cnt_q        <= 32'h0000_0000;
         o_sec_tick       <= 1'b0;
         o_interval_timer <= 10'h000;
      end else begin
         sec_cnt_q  <= tick_w ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001; // RQ18
         o_sec_tick <= tick_w;
         // Clear leaves the interval timer running
         if (tick_w) begin
            o_interval_timer <= int_end_w ? 10'h000 : o_interval_timer + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-second error gathering
   reg [15:0] sec_errs_q;
   reg        sec_any_q;
   reg [15:0] sec_blocks_q;
   reg [3:0]  ses_run_q;
   wire [15:0] errs_now_w = sec_errs_q + {15'h0000, crc_bad_w} + {15'h0000, i_oof};
   wire        any_now_w  = sec_any_q | crc_bad_w | i_frame_err;
   wire [15:0] blk_now_w  = sec_blocks_q + {15'h0000, crc_bad_w};
   wire        es_w       = any_now_w; // RQ15
   wire        ses_w      = (errs_now_w >= `EPM_SES_THRESH); // RQ16
   wire        uas_w      = o_unavailable_state || (ses_w && ses_run_q == `EPM_UAS_RUN - 1);
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         sec_errs_q   <= 16'h0000;
         sec_any_q    <= 1'b0;
         sec_blocks_q <= 16'h0000;
         ses_run_q    <= 4'h0;
         o_unavailable_state <= 1'b0;
         o_frame_bad  <= 1'b0;
      end else begin
         o_frame_bad <= crc_bad_w; // RQ6
         if (tick_w) begin
            sec_errs_q   <= 16'h0000;
            sec_any_q    <= 1'b0;
            sec_blocks_q <= 16'h0000;
            if (ses_w) begin
               ses_run_q <= (ses_run_q == `EPM_UAS_RUN - 1) ? ses_run_q : ses_run_q + 4'h1;
            end else begin
               ses_run_q <= 4'h0;
            end
            // Leaves unavailable state on the first non-severe second
            o_unavailable_state <= ses_w ? uas_w : 1'b0; // RQ17
         end else begin
            sec_errs_q   <= (errs_now_w == 16'hFFFF) ? sec_errs_q : errs_now_w;
            sec_any_q    <= any_now_w;
            sec_blocks_q <= blk_now_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Running counters, kept apart from the history
   reg [15:0] iv_es_q, iv_ses_q, iv_uas_q, iv_bbe_q;
   wire [15:0] add_es_w  = {15'h0000, es_w & ~uas_w};
   wire [15:0] add_ses_w = {15'h0000, ses_w & ~uas_w};
   wire [15:0] add_uas_w = {15'h0000, uas_w};
   wire [15:0] add_bbe_w = (ses_w | uas_w) ? 16'h0000 : blk_now_w;
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_crc_errors               <= {CW{1'b0}};
         o_line_code_violations     <= {CW{1'b0}};
         o_errored_seconds          <= {CW{1'b0}};
         o_severely_errored_seconds <= {CW{1'b0}};
         o_unavailable_seconds      <= {CW{1'b0}};
         o_background_block_errors  <= {CW{1'b0}};
         o_avail_seconds            <= {CW{1'b0}};
         o_error_free_seconds       <= {CW{1'b0}};
         o_total_seconds            <= {CW{1'b0}};
         iv_es_q  <= 16'h0000;
         iv_ses_q <= 16'h0000;
         iv_uas_q <= 16'h0000;
         iv_bbe_q <= 16'h0000;
      end else begin
         // Frame or violation event in the clearing cycle counts from zero, not lost
         if (i_clear) begin
            o_crc_errors           <= {{(CW-1){1'b0}}, crc_bad_w}; // RQ14
            o_line_code_violations <= {{(CW-1){1'b0}}, cv_w}; // RQ14
         end else begin
            o_crc_errors           <= o_crc_errors + {{(CW-1){1'b0}}, crc_bad_w}; // RQ6 RQ10
            o_line_code_violations <= o_line_code_violations + {{(CW-1){1'b0}}, cv_w}; // RQ7
         end
         if (i_clear) begin
            o_errored_seconds          <= {CW{1'b0}};
            o_severely_errored_seconds <= {CW{1'b0}};
            o_unavailable_seconds      <= {CW{1'b0}};
            o_background_block_errors  <= {CW{1'b0}};
            o_avail_seconds            <= {CW{1'b0}};
            o_error_free_seconds       <= {CW{1'b0}};
            o_total_seconds            <= {CW{1'b0}};
         end else if (tick_w) begin
            o_total_seconds <= o_total_seconds + 1'b1;
            if (uas_w) begin
               o_unavailable_seconds <= o_unavailable_seconds + 1'b1; // RQ17
            end else begin
               o_avail_seconds <= o_avail_seconds + 1'b1; // RQ2 RQ3
               if (es_w) o_errored_seconds <= o_errored_seconds + 1'b1; // RQ15
               // A severe second without frame errors is still not error free
               else if (!ses_w) o_error_free_seconds <= o_error_free_seconds + 1'b1; // RQ1
               if (ses_w) o_severely_errored_seconds <= o_severely_errored_seconds + 1'b1; // RQ16
               else o_background_block_errors <= o_background_block_errors
                                                 + {{(CW-16){1'b0}}, blk_now_w}; // RQ4
            end
         end
         if (tick_w) begin
            iv_es_q  <= int_end_w ? 16'h0000 : iv_es_q + add_es_w;
            iv_ses_q <= int_end_w ? 16'h0000 : iv_ses_q + add_ses_w;
            iv_uas_q <= int_end_w ? 16'h0000 : iv_uas_q + add_uas_w;
            iv_bbe_q <= int_end_w ? 16'h0000 : iv_bbe_q + add_bbe_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // 24-hour history of 96 intervals; clear does not touch it
   reg [6:0] wr_ptr_q;
   // Closing second belongs to the interval that it ends
   wire [63:0] iv_word_w = {iv_es_q + add_es_w, iv_uas_q + add_uas_w,
                            iv_ses_q + add_ses_w, iv_bbe_q + add_bbe_w};
   // Reads are relative to newest: index 0 is the last stored interval
   wire [31:0] last_idx_w = DEPTH - 1;
   wire [6:0]  newest_w   = (wr_ptr_q == 7'h00) ? last_idx_w[6:0] : wr_ptr_q - 7'h01;
   wire [31:0] wrap_w     = newest_w + DEPTH - i_hist_rd_idx;
   wire [6:0]  rd_addr_w  = (i_hist_rd_idx > newest_w) ? wrap_w[6:0]
                                                       : newest_w - i_hist_rd_idx;
   wire [63:0] hist_rd_w;
   epm_hist_mem #(.DEPTH(DEPTH), .AW(7), .DW(64)) u_hist (
      .i_clk_sys (i_clk_sys),
      .i_wr_en   (int_end_w), // RQ19
      .i_wr_addr (wr_ptr_q),
      .i_wr_data (iv_word_w),
      .i_rd_addr (rd_addr_w),
      .o_rd_data (hist_rd_w)
   );
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         wr_ptr_q          <= 7'h00;
         o_valid_intervals <= 7'h00;
         o_hist_data       <= 64'h0000_0000_0000_0000;
      end else begin
         o_hist_data <= hist_rd_w;
         if (int_end_w) begin
            wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? 7'h00 : wr_ptr_q + 7'h01; // RQ9 RQ19
            if (o_valid_intervals != DEPTH) o_valid_intervals <= o_valid_intervals + 7'h01; // RQ12
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port status and user alarm text
   reg [7:0] alarm_txt_q [0:`EPM_ALARM_CHARS-1];
   integer k;
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_port_status <= `EPM_PORT_NORMAL;
         o_alarm_char  <= 8'h00;
         o_alarm_user  <= 1'b0;
         for (k = 0; k < `EPM_ALARM_CHARS; k = k + 1) alarm_txt_q[k] <= 8'h20;
      end else begin
         if (!i_port_present) o_port_status <= `EPM_PORT_BLANK; // RQ13
         else if (i_sel_rts ? !i_rts : !i_dtr) o_port_status <= `EPM_PORT_LOSS; // RQ8
         else o_port_status <= `EPM_PORT_NORMAL; // RQ8
         if (i_alarm_wr && i_alarm_idx < `EPM_ALARM_CHARS) alarm_txt_q[i_alarm_idx] <= i_alarm_char; // RQ11
         o_alarm_user <= i_user_alarm_en; // RQ11
         o_alarm_char <= (i_alarm_rd_idx < `EPM_ALARM_CHARS) ? alarm_txt_q[i_alarm_rd_idx] : 8'h00;
      end
   end
   // Ratios RQ2 RQ3: reader divides o_errored_seconds or severe count by
   // o_avail_seconds times 100; dividers left out to save area
endmodule // epm_monitor
`default_nettype wire

// >>> sim/epm_line_model.sv
// Line receiver model: mark strobes with alternating or repeated polarity
`timescale 1ns/100ps
`default_nettype none
module epm_line_model (
   input  wire logic i_clk_sys,
   input  wire logic i_send,
   input  wire logic i_viol,
   output var  logic o_mark_valid,
   output var  logic o_mark_pos
);
   logic pol_q = 1'b0;
   initial o_mark_valid = 1'b0;
   initial o_mark_pos = 1'b0;
   always @(posedge i_clk_sys) begin
      o_mark_valid <= i_send;
      // Idle polarity keeps toggling so a stale level never looks like a mark
      o_mark_pos <= i_send ? (i_viol ? pol_q : ~pol_q) : ~o_mark_pos;
      if (i_send && !i_viol)
         pol_q <= ~pol_q;
   end
endmodule // epm_line_model
`default_nettype wire

// >>> sim/epm_monitor_props.sv
// Port assertions for the E1 performance monitor
`timescale 1ns/100ps
`default_nettype none
module epm_monitor_props #(
   parameter SEC_CYCLES = 10
) (
   input wire logic        i_clk_sys,
   input wire logic        i_reset,
   input wire logic        i_frame_end,
   input wire logic        i_mark_valid,
   input wire logic        i_dtr,
   input wire logic        i_rts,
   input wire logic        i_sel_rts,
   input wire logic        i_port_present,
   input wire logic        i_clear,
   input wire logic [31:0] o_crc_errors,
   input wire logic [31:0] o_line_code_violations,
   input wire logic [9:0]  o_interval_timer,
   input wire logic [1:0]  o_port_status,
   input wire logic        o_frame_bad,
   input wire logic        o_sec_tick,
   input wire logic [6:0]  o_valid_intervals
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   logic [31:0] gap_q;
   logic        seen_q;
   logic        up_q;
   // First tick after reset only arms the gap check
   always_ff @(posedge i_clk_sys or posedge i_reset)
      if (i_reset)
         {gap_q, seen_q, up_q} <= '0;
      else
         {gap_q, seen_q, up_q} <= {o_sec_tick ? 32'h0 : gap_q + 32'h1, seen_q | o_sec_tick, 1'b1};
   ////////////////////////////////////////////////////////////////////////
   property p_crc; !o_frame_bad && !$past(i_clear) |-> $stable(o_crc_errors); endproperty
   property p_bad;
      o_frame_bad && !$past(i_clear) |-> o_crc_errors == $past(o_crc_errors) + 32'h1;
   endproperty
   property p_lcv;
      !$past(i_mark_valid) && !$past(i_clear) |-> $stable(o_line_code_violations);
   endproperty
   property p_clr;
      $past(i_clear) && !$past(i_frame_end) && !$past(i_mark_valid)
         |-> o_crc_errors == 32'h0 && o_line_code_violations == 32'h0;
   endproperty
   property p_blank; up_q && !$past(i_port_present) |-> o_port_status == 2'h2; endproperty
   property p_loss;
      up_q && $past(i_port_present) |-> o_port_status ==
         (($past(i_sel_rts) ? !$past(i_rts) : !$past(i_dtr)) ? 2'h1 : 2'h0);
   endproperty
   property p_tick; o_sec_tick && seen_q |-> gap_q == SEC_CYCLES - 1; endproperty
   property p_hist;
      o_valid_intervals != $past(o_valid_intervals)
         |-> o_interval_timer == 10'h0 && o_valid_intervals == $past(o_valid_intervals) + 7'h1;
   endproperty
   a_crc: assert property (p_crc) else $error("crc count moved");
   a_bad: assert property (p_bad) else $error("bad frame not counted");
   a_lcv: assert property (p_lcv) else $error("violation count moved");
   a_clr: assert property (p_clr) else $error("clear left counts");
   a_blank: assert property (p_blank) else $error("absent port not blank");
   a_loss: assert property (p_loss) else $error("port status wrong");
   a_tick: assert property (p_tick) else $error("second length wrong");
   a_hist: assert property (p_hist) else $error("history step wrong");
   c_bad: cover property (o_frame_bad);
   c_tick: cover property (o_sec_tick);
   c_hist: cover property (o_valid_intervals != $past(o_valid_intervals));
endmodule // epm_monitor_props
bind epm_monitor epm_monitor_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_frame_end(i_frame_end),
   .i_mark_valid(i_mark_valid), .i_dtr(i_dtr), .i_rts(i_rts), .i_sel_rts(i_sel_rts),
   .i_port_present(i_port_present), .i_clear(i_clear), .o_crc_errors(o_crc_errors),
   .o_line_code_violations(o_line_code_violations), .o_interval_timer(o_interval_timer),
   .o_port_status(o_port_status), .o_frame_bad(o_frame_bad), .o_sec_tick(o_sec_tick),
   .o_valid_intervals(o_valid_intervals));
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the E1 performance monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int SECC = 320;
   logic        clk = 0, rst = 1, bv = 0, bt = 0, fs = 0, fe = 0, ferr = 0, out_of_frame_event = 0;
   logic        dtr = 0, rts = 0, selr = 0, pres = 0, uen = 0, awr = 0, clr = 0;
   logic        msend = 0, mviol = 0, mv, mp, frb, tick, uast, ausr;
   logic [5:0]  rxc = 6'h00;
   logic [7:0]  ach = 8'h00, achr, txt [20];
   logic [4:0]  aidx = 5'h00, ardx = 5'h00;
   logic [1:0]  pst;
   logic [63:0] hdat, hkeep;
   logic [31:0] avs, tots;
   logic [9:0]  itim;
   logic [6:0]  vint;
   logic [31:0] crce, lcv, es, severely_errored_second, unavailable_second, bbe, efs, seed = 32'h21B4;
   int          n_fail = 0, n_tests = 0, e_crc = 0, e_lcv = 0;
   int          e_es = 0, e_ses = 0, e_efs = 0, e_bbe = 0, n_sec = 0;
   epm_monitor #(.SEC_CYCLES(SECC), .INT_SECS(4)) dut (
      .i_clk_sys(clk), .i_reset(rst), .i_bit_valid(bv), .i_bit(bt), .i_frame_start(fs),
      .i_frame_end(fe), .i_rx_crc(rxc), .i_frame_err(ferr), .i_oof(out_of_frame_event), .i_mark_valid(mv),
      .i_mark_pos(mp), .i_dtr(dtr), .i_rts(rts), .i_sel_rts(selr), .i_port_present(pres),
      .i_user_alarm_en(uen), .i_alarm_char(ach), .i_alarm_idx(aidx), .i_alarm_wr(awr),
      .i_alarm_rd_idx(ardx), .i_clear(clr), .i_hist_rd_idx(7'h00), .o_crc_errors(crce),
      .o_line_code_violations(lcv), .o_errored_seconds(es), .o_severely_errored_seconds(severely_errored_second),
      .o_unavailable_seconds(unavailable_second), .o_background_block_errors(bbe), .o_avail_seconds(avs),
      .o_error_free_seconds(efs), .o_total_seconds(tots), .o_interval_timer(itim),
      .o_unavailable_state(uast), .o_port_status(pst), .o_alarm_char(achr), .o_alarm_user(ausr),
      .o_frame_bad(frb), .o_sec_tick(tick), .o_valid_intervals(vint), .o_hist_data(hdat));
   epm_line_model u_line (.i_clk_sys(clk), .i_send(msend), .i_viol(mviol), .o_mark_valid(mv),
      .o_mark_pos(mp));
   always #10 clk = ~clk;
   // Seconds since reset; the interval timer ignores clear
   always @(posedge tick) n_sec++;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run();
      if (n_fail == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic next_tick();
      cyc(1);
      for (int i = 0; i < 2 * SECC && tick !== 1'b1; i++)
         cyc(1);
   endtask
   task automatic frame(input bit bad);
      logic [5:0]  c;
      logic [31:0] d;
      c = 6'h00;
      d = rnd();
      for (int i = 0; i < 32; i++) begin
         cyc(1);
         bv = 1'b1;
         fs = (i == 0);
         bt = d[i];
         c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
      end
      cyc(1);
      bv = 1'b0;
      fe = 1'b1;
      rxc = bad ? ~c : c;
      e_crc += bad;
      cyc(1);
      fe = 1'b0;
      rxc = ~rxc;
      check("frame_bad", {31'h0, bad}, {31'h0, frb});
      cyc(1);
      check("crc_errors", e_crc, crce);
   endtask
   // Kinds: 0 clean, 1 framing error, 2 bad check, 3 severe, 4 severe unchecked, 5 quiet
   task automatic second(input int k);
      ferr = (k == 1);
      out_of_frame_event = (k == 3 || k == 4);
      if (k == 2)
         frame(1'b1);
      cyc(out_of_frame_event ? 305 : 1);
      ferr = 1'b0;
      out_of_frame_event = 1'b0;
      next_tick();
      e_es += (k == 1 || k == 2);
      e_ses += (k == 3);
      e_efs += (k == 0);
      e_bbe += (k == 2);
      if (k < 4) begin
         check("errored_seconds", e_es, es);
         check("severe_seconds", e_ses, severely_errored_second);
         check("error_free_seconds", e_efs, efs);
         check("block_errors", e_bbe, bbe);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (SECC * 40) @(posedge clk);
      n_fail++;
      complete_run();
   end
   initial begin
      cyc(3);
      rst = 1'b0;
      ardx = 5'h05;
      cyc(2);
      check("alarm_default", 8'h20, achr);
      for (int k = 0; k < 16; k++) begin
         {pres, selr, dtr, rts} = k[3:0];
         cyc(2);
         check("port_status", !pres ? 2 : ((selr ? !rts : !dtr) ? 1 : 0), pst);
      end
      uen = 1'b1;
      // Index 20 is refused; an aliased write would spoil a lower slot
      for (int i = 0; i < 21; i++) begin
         cyc(1);
         awr = 1'b1;
         aidx = i[4:0];
         ach = 8'(rnd());
         if (i < 20)
            txt[i] = ach;
      end
      cyc(1);
      awr = 1'b0;
      for (int i = 0; i < 20; i++) begin
         ardx = i[4:0];
         cyc(2);
         check("alarm_text", txt[i], achr);
      end
      check("alarm_user", 1, ausr);
      for (int i = 0; i < 8; i++)
         frame(bit'(rnd() & 32'h1));
      for (int i = 0; i < 40; i++) begin
         msend = 1'b1;
         mviol = i > 0 && (rnd() & 32'h3) == 32'h0;
         e_lcv += mviol;
         cyc(1);
      end
      msend = 1'b0;
      cyc(3);
      check("line_code_violations", e_lcv, lcv);
      next_tick();
      cyc(4);
      hkeep = hdat;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      {e_crc, e_lcv} = '0;
      cyc(2);
      check("crc_cleared", e_crc, crce);
      check("lcv_cleared", e_lcv, lcv);
      check("history_kept", 1, {31'h0, hdat === hkeep});
      for (int k = 0; k < 4; k++)
         second(k);
      for (int i = 0; i < 11; i++)
         second(4);
      check("unavailable_state", 1, uast);
      check("unavailable_count", 1, {31'h0, unavailable_second > 32'h0});
      second(5);
      check("available_again", 0, uast);
      check("total_seconds", 16, tots);
      check("avail_plus_unavail", 16, avs + unavailable_second);
      check("interval_timer", n_sec % 4, itim);
      check("valid_intervals", n_sec / 4, vint);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
